// ==== core/ddif_top.sv ====
// drive digital input conditioning and input/output function logic
// apb slave with zero wait states; lines synchronous to MCLK
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ddif_top #(
  parameter int NIN  = ddif_pkg::NUM_IN,
  parameter int NOUT = ddif_pkg::NUM_OUT
) (
  // clock, reset, enable
  input  wire logic                       MCLK,
  input  wire logic                       RESET_N,
  input  wire logic                       CE,
  // apb slave
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [11:0]                PADDR,
  input  wire logic [31:0]                PWDATA,
  output logic      [31:0]                PRDATA,
  output logic                            PREADY,
  output logic                            PSLVERR,
  // drive side
  input  wire logic [NIN-1:0]             IN_LINES,
  input  wire logic                       PANEL_RESET,
  input  wire logic                       FAULT_ACTIVE,
  input  wire logic                       MOTION_BUSY,
  input  wire logic                       AT_ZERO_VEL,
  input  wire logic [31:0]                POS_FEEDBACK,
  output logic      [NOUT-1:0]            OUT_LINES,
  output logic                            FAULT_CLEAR,
  output logic                            MOTION_ABORT,
  output logic                            STOP_DECEL,
  output logic                            HOLD_POS,
  output logic                            MOTION_INHIBIT,
  output logic                            JOG_RESUME,
  output logic                            DECIMAL_POINT,
  output logic      [ddif_pkg::SEL_W-1:0] PRESET_INDEX,
  output logic                            PRESET_CHANGE,
  output logic                            TORQUE_CLAMP,
  output logic                            HOME_CAPTURE,
  output logic      [31:0]                HOME_POS
);
  import ddif_pkg::*;

  // the mapping logic only serves the documented line counts
  if (NIN != NUM_IN || NOUT != NUM_OUT) begin : g_bad_cfg
    $error("line counts must match five inputs and three outputs");
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [3:0]       in_map_q  [NUM_FIN];
  logic [NUM_FOUT-1:0] out_sel_q [NUM_OUT];
  logic [NUM_FIN-1:0] pol_q;
  logic [NUM_FIN-1:0] always_q;
  logic [NIN-1:0]   frc_en_q;
  logic [NIN-1:0]   frc_val_q;
  logic [NOUT-1:0]  out_pol_q;
  logic [DEB_W-1:0] deb_q [NIN];
  logic             wr_en;
  logic [NUM_FIN-1:0] func_q;
  logic [31:0]      home_q;

  // write strobe only at the access edge
  assign wr_en = CE && PSEL && PENABLE && PWRITE;

  // decoding of register slot index from a base address
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] base,
                               input int          idx);
    return a == base + 12'(idx * 4);
  endfunction

  // [RQ2] function to line mapping
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < NUM_FIN; i++) in_map_q[i] <= 4'h0;
      for (int j = 0; j < NUM_OUT; j++) out_sel_q[j] <= '0;
    end else if (wr_en) begin
      for (int i = 0; i < NUM_FIN; i++)
        if (hit(PADDR, A_IN_MAP, i)) in_map_q[i] <= PWDATA[3:0];
      for (int j = 0; j < NUM_OUT; j++)
        if (hit(PADDR, A_OUT_MAP, j))
          out_sel_q[j] <= PWDATA[NUM_FOUT-1:0];
    end
  end

  // [RQ9] force settings cleared on every reset
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pol_q     <= '0;
      always_q  <= '0;
      frc_en_q  <= '0;
      frc_val_q <= '0;
      out_pol_q <= '0;
    end else if (wr_en) begin
      if (PADDR == A_POL)     pol_q     <= PWDATA[NUM_FIN-1:0];
      if (PADDR == A_ALWAYS)  always_q  <= PWDATA[NUM_FIN-1:0];
      if (PADDR == A_FRC_EN)  frc_en_q  <= PWDATA[NIN-1:0];
      if (PADDR == A_FRC_VAL) frc_val_q <= PWDATA[NIN-1:0];
      if (PADDR == A_OUT_POL) out_pol_q <= PWDATA[NOUT-1:0];
    end
  end

  // debounce times in clock cycles, zero disables
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int i = 0; i < NIN; i++) deb_q[i] <= '0;
    end else if (wr_en) begin
      for (int i = 0; i < NIN; i++)
        if (hit(PADDR, A_DEB_BASE, i)) deb_q[i] <= PWDATA[DEB_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per-line debounce and forcing
  logic [NIN-1:0] raw_prev_q;
  logic [NIN-1:0] deb_on_q;
  logic [NIN-1:0] line_lvl;
  logic [DEB_W-1:0] cnt_q [NIN];

  genvar g;
  generate
    for (g = 0; g < NIN; g++) begin : gl
      // [RQ6] [RQ21] uninterrupted on time, restart on drop
      always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
          cnt_q[g]    <= '0;
          deb_on_q[g] <= 1'b0;
        end else if (CE) begin
          if (!IN_LINES[g]) begin
            cnt_q[g]    <= '0;
            deb_on_q[g] <= 1'b0;
          end else if (cnt_q[g] + 1'b1 >= deb_q[g]) begin
            deb_on_q[g] <= 1'b1;
          end else begin
            cnt_q[g] <= cnt_q[g] + 1'b1;
          end
        end
      end
      // [RQ8] [RQ22] forcing applied on the line level, before polarity and always
      assign line_lvl[g] = frc_en_q[g] ? frc_val_q[g] : deb_on_q[g];
    end
  endgenerate

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) raw_prev_q <= '0;
    else if (CE)  raw_prev_q <= IN_LINES;
  end

  ////////////////////////////////////////////////////////////////////
  // input function levels
  logic [NUM_FIN-1:0] func_d;
  always_comb begin
    logic lv;
    lv = 1'b0;
    for (int i = 0; i < NUM_FIN; i++) begin
      lv = in_map_q[i][MAP_EN_BIT] && (32'(in_map_q[i][2:0]) < NIN)
           && line_lvl[in_map_q[i][2:0]];
      // [RQ3] [RQ4] polarity, only for an assigned line
      func_d[i] = in_map_q[i][MAP_EN_BIT] && (lv ^ pol_q[i]);
      // [RQ5] always active wins over line state
      if (always_q[i]) func_d[i] = 1'b1;
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) func_q <= '0;
    else if (CE)  func_q <= func_d;
  end

  ////////////////////////////////////////////////////////////////////
  // home capture at the raw edge of the home sensor line
  logic [2:0] home_ln;
  logic       home_raw_rise;
  assign home_ln = in_map_q[FI_HOME_SNS][2:0];
  assign home_raw_rise = in_map_q[FI_HOME_SNS][MAP_EN_BIT]
                         && (32'(home_ln) < NIN)
                         && IN_LINES[home_ln] && !raw_prev_q[home_ln];
  logic       home_pend_q;
  logic [31:0] home_pos_q;
  logic       home_cap_q;
  // [RQ7] latch at raw edge, report once debounced
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      home_pend_q <= 1'b0;
      home_pos_q  <= '0;
      home_q      <= '0;
      home_cap_q  <= 1'b0;
    end else if (CE) begin
      home_cap_q <= 1'b0;
      if (home_raw_rise) begin
        home_pos_q  <= POS_FEEDBACK;
        home_pend_q <= 1'b1;
      end else if (home_pend_q && func_q[FI_HOME_SNS]) begin
        home_q      <= home_pos_q;
        home_cap_q  <= 1'b1;
        home_pend_q <= 1'b0;
      end else if (!IN_LINES[home_ln]) begin
        home_pend_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // function logic
  logic       rst_or_q;
  logic       stop_prev_q;
  logic       fclr_q;
  logic       abort_q;
  logic       inhib_q;
  logic       jres_q;
  logic       dp_q;
  logic       tq_q;
  logic       brake_q;
  logic [SEL_W-1:0] pidx_q;
  logic       pchg_q;
  logic       rst_or;
  logic       jog_lvl;
  logic [SEL_W-1:0] pidx_d;
  ddif_stop_t stop_q;

  assign rst_or  = func_q[FI_RESET] | PANEL_RESET;
  assign jog_lvl = func_q[FI_JOG_P] | func_q[FI_JOG_N];
  // [RQ17] weights one, two and four
  assign pidx_d = {func_q[FI_VP3], func_q[FI_VP2], func_q[FI_VP1]};

  // [RQ12] clear only on a rising edge of the combined reset
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_or_q <= 1'b0;
      fclr_q   <= 1'b0;
    end else if (CE) begin
      rst_or_q <= rst_or;
      fclr_q   <= rst_or && !rst_or_q;
    end
  end

  // [RQ13] abort then decelerate, hold at zero velocity
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      stop_q      <= DDIF_RUN;
      stop_prev_q <= 1'b0;
      abort_q     <= 1'b0;
    end else if (CE) begin
      stop_prev_q <= func_q[FI_STOP];
      abort_q     <= func_q[FI_STOP] && !stop_prev_q && MOTION_BUSY;
      case (stop_q)
        DDIF_RUN:   if (func_q[FI_STOP]) stop_q <= DDIF_DECEL;
        DDIF_DECEL: if (!func_q[FI_STOP]) stop_q <= DDIF_RUN;
                    else if (AT_ZERO_VEL) stop_q <= DDIF_HOLD;
        DDIF_HOLD:  if (!func_q[FI_STOP]) stop_q <= DDIF_RUN;
        default:    stop_q <= DDIF_RUN;
      endcase
    end
  end

  // [RQ14] [RQ15] inhibit while stopped, resume held jog
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      inhib_q <= 1'b0;
      jres_q  <= 1'b0;
    end else if (CE) begin
      inhib_q <= func_q[FI_STOP];
      jres_q  <= !func_q[FI_STOP] && stop_prev_q && jog_lvl;
    end
  end

  // [RQ16] decimal point lit only when running and enabled
  // [RQ19] torque clamp follows its function
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dp_q <= 1'b0;
      tq_q <= 1'b0;
    end else if (CE) begin
      dp_q <= !func_q[FI_STOP] && func_q[FI_ENABLE];
      tq_q <= func_q[FI_TQ_LIM];
    end
  end

  // [RQ18] new preset index ramps directly, no stop request
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pidx_q <= '0;
      pchg_q <= 1'b0;
    end else if (CE) begin
      pidx_q <= pidx_d;
      pchg_q <= pidx_d != pidx_q;
    end
  end

  // [RQ10] [RQ11] brake output, release has priority
  logic brake_d;
  always_comb begin
    brake_d = func_q[FI_ENABLE] && !FAULT_ACTIVE;
    if (func_q[FI_BRK_CTL]) brake_d = 1'b0;
    if (func_q[FI_BRK_REL]) brake_d = 1'b1;
  end
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) brake_q <= 1'b0;
    else if (CE)  brake_q <= brake_d;
  end

  ////////////////////////////////////////////////////////////////////
  // output lines
  logic [NUM_FOUT-1:0] ofunc;
  logic [NOUT-1:0]     out_q;
  assign ofunc = {4'h0, stop_q != DDIF_RUN, !FAULT_ACTIVE,
                  FAULT_ACTIVE, brake_q};
  // [RQ1] [RQ20] polarised OR of assigned functions per line
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) out_q <= '0;
    else if (CE) begin
      for (int j = 0; j < NOUT; j++)
        out_q[j] <= (|(out_sel_q[j] & ofunc)) ^ out_pol_q[j];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // apb read path, zero wait states
  logic [31:0] rd_d;
  logic [31:0] rd_q;
  always_comb begin
    rd_d = RD_ZERO;
    for (int i = 0; i < NUM_FIN; i++)
      if (hit(PADDR, A_IN_MAP, i)) rd_d = {28'h0, in_map_q[i]};
    for (int j = 0; j < NUM_OUT; j++)
      if (hit(PADDR, A_OUT_MAP, j)) rd_d = {24'h0, out_sel_q[j]};
    for (int i = 0; i < NIN; i++)
      if (hit(PADDR, A_DEB_BASE, i)) rd_d = {16'h0, deb_q[i]};
    case (PADDR)
      A_POL:      rd_d = {16'h0, pol_q};
      A_ALWAYS:   rd_d = {16'h0, always_q};
      A_FRC_EN:   rd_d = {27'h0, frc_en_q};
      A_FRC_VAL:  rd_d = {27'h0, frc_val_q};
      A_OUT_POL:  rd_d = {29'h0, out_pol_q};
      A_STATUS:   rd_d = {22'h0, stop_q, out_q, line_lvl};
      A_FUNCS:    rd_d = {16'h0, func_q};
      A_HOME_POS: rd_d = home_q;
      default:    ;
    endcase
  end
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) rd_q <= '0;
    else if (CE && PSEL && !PENABLE && !PWRITE) rd_q <= rd_d;
  end

  // stop state flags registered so the outputs come from flip-flops
  logic decel_q;
  logic hold_q;
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      decel_q <= 1'b0;
      hold_q  <= 1'b0;
    end else if (CE) begin
      decel_q <= stop_q == DDIF_DECEL;
      hold_q  <= stop_q == DDIF_HOLD;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registered outputs; PREADY and PSLVERR are tied to constants
  assign PRDATA         = rd_q;
  assign PREADY         = 1'b1;
  assign PSLVERR        = 1'b0;
  assign OUT_LINES      = out_q;
  assign FAULT_CLEAR    = fclr_q;
  assign MOTION_ABORT   = abort_q;
  assign STOP_DECEL     = decel_q;
  assign HOLD_POS       = hold_q;
  assign MOTION_INHIBIT = inhib_q;
  assign JOG_RESUME     = jres_q;
  assign DECIMAL_POINT  = dp_q;
  assign PRESET_INDEX   = pidx_q;
  assign PRESET_CHANGE  = pchg_q;
  assign TORQUE_CLAMP   = tq_q;
  assign HOME_CAPTURE   = home_cap_q;
  assign HOME_POS       = home_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  a_brake_release: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && func_q[FI_BRK_REL] |=> brake_q) // [RQ11]
    else $error("brake not released");
  a_brake_engage: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && func_q[FI_BRK_CTL] && !func_q[FI_BRK_REL] |=> !brake_q) // [RQ10]
    else $error("brake not engaged");
  a_fault_edge: assert property (@(posedge MCLK) disable iff (!RESET_N)
    fclr_q |-> $past(CE) && !$past(rst_or_q)) // [RQ12]
    else $error("fault clear without edge");
  a_stop_inhibit: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && func_q[FI_STOP] |=> inhib_q && !jres_q) // [RQ14]
    else $error("motion not inhibited");
  a_dp_off: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && (func_q[FI_STOP] || !func_q[FI_ENABLE]) |=> !dp_q) // [RQ16]
    else $error("decimal point lit");
  a_preset_index: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE |=> pidx_q == $past(pidx_d)) // [RQ17]
    else $error("preset index wrong");
  a_torque_clamp: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE |=> tq_q == $past(func_q[FI_TQ_LIM])) // [RQ19]
    else $error("torque clamp wrong");
  a_stop_decel: assert property (@(posedge MCLK) disable iff (!RESET_N) // [RQ13]
    CE && stop_q == DDIF_RUN && func_q[FI_STOP] |=> stop_q == DDIF_DECEL)
    else $error("stop not decelerating");
  a_force_line: assert property (@(posedge MCLK) disable iff (!RESET_N)
    frc_en_q[0] |-> line_lvl[0] == frc_val_q[0]) // [RQ8]
    else $error("force ignored");
  a_debounce_drop: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CE && !IN_LINES[0] |=> !deb_on_q[0] && cnt_q[0] == '0) // [RQ21]
    else $error("debounce not restarted");
endmodule
`default_nettype wire

// ==== core/ddif_pkg.sv ====
// constants, modes and line counts for the drive digital input functions
// assumes one drive clock and the register layout chosen below
//
// Operation
// [RQ1] five input lines, three output lines
// [RQ2] any function maps to any line
// [RQ3] active-on: voltage means asserted
// [RQ4] active-off: no voltage means asserted
// [RQ5] always-active overrides line and assignment
// [RQ6] line on only after debounce time
// [RQ7] home captured at raw rising edge
// [RQ8] forcing overrides physical level for functions
// [RQ9] forced states cleared at reset
// [RQ10] brake control engages brake unless released
// [RQ11] brake release always holds brake output
// [RQ12] faults cleared on reset-or rising edge
// [RQ13] stop aborts motion, decelerates, holds
// [RQ14] stop blocks jog, index and home
// [RQ15] level jog resumes when stop drops
// [RQ16] decimal point off on stop or disable
// [RQ17] preset index weighted one two four
// [RQ18] preset change ramps without stopping
// [RQ19] torque limit enable clamps torque
// [RQ20] output line is polarised OR of functions
// [RQ21] debounce count restarts on any drop
// [RQ22] polarity, always, force applied in order; code forces the line level first, then applies polarity, then always
package ddif_pkg;
  localparam int NUM_IN   = 5;
  localparam int NUM_OUT  = 3;
  localparam int NUM_FIN  = 16;
  localparam int NUM_FOUT = 8;
  localparam int SEL_W    = 3;
  localparam int DEB_W    = 16;
  // input function indices
  localparam int FI_ENABLE = 0;
  localparam int FI_BRK_CTL = 1;
  localparam int FI_BRK_REL = 2;
  localparam int FI_RESET = 3;
  localparam int FI_STOP = 4;
  localparam int FI_JOG_P = 5;
  localparam int FI_JOG_N = 6;
  localparam int FI_JOG_F = 7;
  localparam int FI_INDEX = 8;
  localparam int FI_HOME = 9;
  localparam int FI_HOME_SNS = 10;
  localparam int FI_VP1 = 11;
  localparam int FI_VP2 = 12;
  localparam int FI_VP3 = 13;
  localparam int FI_TQ_LIM = 14;
  // output function indices
  localparam int FO_BRAKE = 0;
  localparam int FO_FAULT = 1;
  localparam int FO_OK = 2;
  localparam int FO_STOPPED = 3;
  // apb register byte offsets
  localparam logic [11:0] A_IN_MAP   = 12'h000; // 16 words, function map
  localparam logic [11:0] A_OUT_MAP  = 12'h040; // 3 words, output map
  localparam logic [11:0] A_POL      = 12'h050;
  localparam logic [11:0] A_ALWAYS   = 12'h054;
  localparam logic [11:0] A_FRC_EN   = 12'h058;
  localparam logic [11:0] A_FRC_VAL  = 12'h05c;
  localparam logic [11:0] A_OUT_POL  = 12'h060;
  localparam logic [11:0] A_STATUS   = 12'h064;
  localparam logic [11:0] A_DEB_BASE = 12'h080; // 5 words, debounce cycles
  localparam logic [11:0] A_FUNCS    = 12'h0a0;
  localparam logic [11:0] A_HOME_POS = 12'h0a4;
  // map word field: bit 3 assigns, bits 2:0 select line
  localparam int MAP_EN_BIT = 3;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // stop handling states
  typedef enum logic [1:0] {
    DDIF_RUN  = 2'b00,
    DDIF_DECEL = 2'b01,
    DDIF_HOLD = 2'b10
  } ddif_stop_t;
endpackage

// ==== sim/ddif_plc_model.sv ====
// plc stand-in that sources the drive's discrete input lines
// assumes the sequence changes its wanted levels just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ddif_plc_model (
  // clock
  input  wire logic       clk,
  // levels the sequence asks for
  input  wire logic [4:0] want,
  // drive side
  output logic      [4:0] lines
);
  // relay outputs switch on the edge, never mid-cycle, so the drive
  // never sees a line move inside its sampling window
  initial begin
    lines = 5'h00;
  end
  always @(posedge clk) begin
    lines <= want;
  end
endmodule
`default_nettype wire

// ==== sim/tb_drive_digital_input_functions.sv ====
// self-checking bench for the drive input and output function block
// assumes ddif_pkg register offsets and the zero-wait apb slave
`timescale 1ns/1ps
`default_nettype none
module tb_drive_digital_input_functions;
  import ddif_pkg::*;
  logic        mclk, reset_n, psel, penable, pwrite, panel_reset;
  logic        fault_active, motion_busy, at_zero_vel;
  logic [11:0] paddr;
  logic [31:0] pwdata, pos_fb, prdata, home_pos, q;
  logic [4:0]  want, in_lines;
  logic [2:0]  out_lines, preset_index;
  logic        pready, pslverr, fault_clear, motion_abort, stop_decel;
  logic        hold_pos, motion_inhibit, jog_resume, decimal_point;
  logic        preset_change, torque_clamp, home_capture;
  int          fail_count, comparisons, n_fc, n_ab, n_jr, n_pc, n_hc;
  int          n_tq, b;

  ddif_top dut (
    .MCLK(mclk), .RESET_N(reset_n), .CE(1'b1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IN_LINES(in_lines), .PANEL_RESET(panel_reset),
    .FAULT_ACTIVE(fault_active), .MOTION_BUSY(motion_busy),
    .AT_ZERO_VEL(at_zero_vel), .POS_FEEDBACK(pos_fb),
    .OUT_LINES(out_lines), .FAULT_CLEAR(fault_clear),
    .MOTION_ABORT(motion_abort), .STOP_DECEL(stop_decel),
    .HOLD_POS(hold_pos), .MOTION_INHIBIT(motion_inhibit),
    .JOG_RESUME(jog_resume), .DECIMAL_POINT(decimal_point),
    .PRESET_INDEX(preset_index), .PRESET_CHANGE(preset_change),
    .TORQUE_CLAMP(torque_clamp), .HOME_CAPTURE(home_capture),
    .HOME_POS(home_pos)
  );
  ddif_plc_model plc (.clk(mclk), .want(want), .lines(in_lines));

  ////////////////////////////////////////////////////////////////////////
  // clock and pulse counters; pulses stand one cycle so count per edge
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(negedge mclk) begin
    n_fc <= n_fc + int'(fault_clear === 1'b1);
    n_ab <= n_ab + int'(motion_abort === 1'b1);
    n_jr <= n_jr + int'(jog_resume === 1'b1);
    n_pc <= n_pc + int'(preset_change === 1'b1);
    n_hc <= n_hc + int'(home_capture === 1'b1);
    n_tq <= n_tq + int'(torque_clamp === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic map(input int fn, input int ln);
    apb(1'b1, A_IN_MAP + 12'(4 * fn), 32'(8 + ln));
  endtask
  task automatic unmap(input int fn);
    apb(1'b1, A_IN_MAP + 12'(4 * fn), 32'h0);
  endtask
  task automatic setl(input logic [4:0] v, input int n);
    @(posedge mclk);
    want <= v;
    repeat (n) @(posedge mclk);
  endtask
  task automatic rst();
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
  endtask

  // watchdog: a hang counts as a mismatch and ends the run
  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {psel, penable, pwrite, panel_reset, fault_active} = '0;
    {motion_busy, at_zero_vel, paddr, pwdata, pos_fb, want} = '0;
    reset_n = 1'b0;
    rst();
    apb(1'b0, A_POL, 32'h0);
    check(q, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    check(q, 32'h0);
    // polarity, always active and forcing on the torque limit input
    map(FI_ENABLE, 0);
    map(FI_TQ_LIM, 1);
    setl(5'h01, 8);
    check(32'(torque_clamp), 32'h0);
    setl(5'h03, 8);
    check(32'(torque_clamp), 32'h1);
    apb(1'b1, A_POL, 32'hffff_ffff);
    setl(5'h03, 8);
    check(32'(torque_clamp), 32'h0);
    setl(5'h01, 8);
    check(32'(torque_clamp), 32'h1);
    apb(1'b1, A_POL, 32'h0);
    unmap(FI_TQ_LIM);
    apb(1'b1, A_ALWAYS, 32'h1 << FI_TQ_LIM);
    setl(5'h01, 8);
    check(32'(torque_clamp), 32'h1);
    apb(1'b1, A_ALWAYS, 32'h0);
    map(FI_TQ_LIM, 1);
    apb(1'b1, A_FRC_EN, 32'h2);
    apb(1'b1, A_FRC_VAL, 32'h2);
    setl(5'h01, 8);
    check(32'(torque_clamp), 32'h1);
    apb(1'b1, A_FRC_VAL, 32'h0);
    setl(5'h03, 8);
    check(32'(torque_clamp), 32'h0);
    // a reset in mid-run drops the forced state
    rst();
    apb(1'b0, A_FRC_EN, 32'h0);
    check(q, 32'h0);
    map(FI_ENABLE, 0);
    map(FI_TQ_LIM, 1);
    setl(5'h03, 8);
    check(32'(torque_clamp), 32'h1);
    // short highs separated by a drop must never qualify
    setl(5'h01, 4);
    apb(1'b1, A_DEB_BASE + 12'h004, 32'd10);
    b = n_tq;
    repeat (2) begin
      setl(5'h03, 6);
      setl(5'h01, 2);
    end
    setl(5'h01, 6);
    check(32'(n_tq - b), 32'h0);
    setl(5'h03, 18);
    check(32'(torque_clamp), 32'h1);
    unmap(FI_TQ_LIM);
    apb(1'b1, A_DEB_BASE + 12'h004, 32'h0);
    // home position taken at the raw edge, not after debounce
    map(FI_HOME_SNS, 3);
    apb(1'b1, A_DEB_BASE + 12'h00c, 32'd10);
    b = n_hc;
    pos_fb <= 32'h0000_1234;
    setl(5'h09, 4);
    pos_fb <= 32'h0000_5678;
    setl(5'h09, 20);
    check(home_pos, 32'h0000_1234);
    check(32'(n_hc - b), 32'h1);
    apb(1'b0, A_HOME_POS, 32'h0);
    check(q, 32'h0000_1234);
    unmap(FI_HOME_SNS);
    apb(1'b1, A_DEB_BASE + 12'h00c, 32'h0);
    // brake table over enable, fault, control and release
    map(FI_BRK_CTL, 1);
    map(FI_BRK_REL, 2);
    apb(1'b1, A_OUT_MAP, 32'h1 << FO_BRAKE);
    for (int i = 0; i < 16; i++) begin
      fault_active <= i[1];
      setl({2'b00, i[3], i[2], i[0]}, 8);
      check(32'(out_lines[0]),
            32'(i[3] | (i[0] & ~i[1] & ~i[2])));
    end
    fault_active <= 1'b0;
    unmap(FI_BRK_CTL);
    unmap(FI_BRK_REL);
    // fault clear needs a rising edge of line or panel button
    map(FI_RESET, 3);
    b = n_fc;
    setl(5'h09, 10);
    panel_reset <= 1'b1;
    setl(5'h09, 10);
    check(32'(n_fc - b), 32'h1);
    setl(5'h01, 4);
    panel_reset <= 1'b0;
    setl(5'h01, 4);
    panel_reset <= 1'b1;
    setl(5'h01, 10);
    check(32'(n_fc - b), 32'h2);
    unmap(FI_RESET);
    // stop aborts, holds, blocks jog, resumes jog on release
    map(FI_STOP, 4);
    map(FI_JOG_P, 2);
    apb(1'b1, A_OUT_MAP + 12'h004, 32'h1 << FO_STOPPED);
    motion_busy <= 1'b1;
    setl(5'h01, 8);
    check(32'(decimal_point), 32'h1);
    b = n_ab;
    setl(5'h11, 8);
    check(32'(n_ab - b), 32'h1);
    check(32'(stop_decel), 32'h1);
    check(32'(motion_inhibit), 32'h1);
    check(32'(decimal_point), 32'h0);
    check(32'(out_lines[1]), 32'h1);
    at_zero_vel <= 1'b1;
    apb(1'b1, A_OUT_POL, 32'h2);
    setl(5'h15, 8);
    check(32'(hold_pos), 32'h1);
    check(32'(out_lines[1]), 32'h0);
    b = n_jr;
    setl(5'h05, 8);
    check(32'(n_jr - b), 32'h1);
    check(32'(motion_inhibit), 32'h0);
    setl(5'h04, 8);
    check(32'(decimal_point), 32'h0);
    unmap(FI_STOP);
    unmap(FI_JOG_P);
    // every preset index, each change signalled once
    map(FI_VP1, 1);
    map(FI_VP2, 2);
    map(FI_VP3, 3);
    setl(5'h01, 8);
    b = n_pc;
    for (int i = 1; i <= 8; i++) begin
      setl({1'b0, 3'(i % 8), 1'b1}, 8);
      check(32'(preset_index), 32'(i % 8));
    end
    check(32'(n_pc - b), 32'd8);
    tally_and_finish();
  end
endmodule
`default_nettype wire
